// File: ttib_pkg.sv
// package: constants, modes and state encoding for the translate-test-increment unit
package ttib_pkg;
   // ---------------------------------------------------------------
   // address representation modes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      TTIB_MODE_COMPACT   = 2'h0,  // 16-bit word operands
      TTIB_MODE_SEGMENTED = 2'h1,  // 32-bit longword operands
      TTIB_MODE_LINEAR    = 2'h2   // 32-bit longword operands
   } ttib_mode_t;

   // ---------------------------------------------------------------
   // sequencer states, gray coded along the path
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      TTIB_ST_IDLE   = 3'h0,  // waiting for start
      TTIB_ST_TARGET = 3'h1,  // reading target byte
      TTIB_ST_XLATE  = 3'h3,  // reading translated byte
      TTIB_ST_DONE   = 3'h2   // retire pulse
   } ttib_state_t;

   // ---------------------------------------------------------------
   // widths, steps and reset values
   // ---------------------------------------------------------------
   localparam int          ADDR_W        = 32;          // full address width
   localparam int          WORD_W        = 16;          // compact operand width
   localparam int          CNT_W         = 16;          // counter width
   localparam int          TABLE_ENTRIES = 256;         // max table size
   localparam logic [31:0] PTR_STEP      = 32'h0000_0001; // pointer increment
   localparam logic [15:0] CNT_STEP      = 16'h0001;    // counter decrement
   localparam logic [31:0] ADDR_RST      = 32'h0000_0000; // address reset value
   localparam logic [15:0] CNT_RST       = 16'h0000;    // counter reset value
   localparam logic [7:0]  BYTE_RST      = 8'h00;       // byte reset value
endpackage

// File: ttib_unit.sv
// module: execution unit for one translate-test-and-increment byte step
// ---------------------------------------------------------------
// How it works
// RULE1: read target byte at string pointer
// RULE2: address is table base plus zero-extended byte
// RULE3: fetch translated byte into result slot
// RULE4: null flag from result; others unchanged
// RULE5: string pointer advances by one afterwards
// RULE6: counter minus one; exhausted when zero
// RULE7: table base never written back
// RULE8: caller keeps operand registers distinct
// RULE9: table holds up to 256 byte entries
// RULE10: operands 16 bits compact, else 32
// RULE11: one iteration only, in order, then retire
// RULE12: counter wraps modulo 65536
// ---------------------------------------------------------------
`timescale 1ns/1ps
module ttib_unit (
   // clock and reset
   input  wire logic                clk_i,
   input  wire logic                rstn_i,
   // instruction issue
   input  wire logic                start_i,          // one-cycle start pulse
   input  wire ttib_pkg::ttib_mode_t pointer_operand_mode_i,
   input  wire logic [31:0]         string_pointer_i,
   input  wire logic [31:0]         table_base_i,
   input  wire logic [15:0]         counter_i,
   // memory read port
   output logic                     mem_req_o,        // held from start through both reads, until mem_ack_i answers the table read
   output logic [31:0]              mem_addr_o,
   input  wire logic                mem_ack_i,
   input  wire logic [7:0]          mem_rdata_i,
   // results
   output logic                     busy_o,
   output logic                     done_o,           // one-cycle retire pulse
   output logic [7:0]               result_byte_slot_o,
   output logic [31:0]              string_pointer_o,
   output logic [15:0]              counter_o,
   output logic                     null_flag_o,
   output logic                     exhausted_flag_o
);

   // ---------------------------------------------------------------
   // state record
   // ---------------------------------------------------------------
   typedef struct packed {
      ttib_pkg::ttib_state_t st;    // sequencer state
      logic                  wide;  // longword operands
      logic                  busy;  // instruction in flight
      logic [31:0]           ptr;   // working string pointer
      logic [31:0]           base;  // latched table base
      logic [15:0]           cnt;   // working counter
      logic                  req;   // memory request
      logic [31:0]           addr;  // memory address
      logic                  done;  // retire pulse
      logic [7:0]            res;   // result byte
      logic                  nul;   // null flag
      logic                  exh;   // exhausted flag
   } ttib_regs_t;

   ttib_regs_t s_q;  // registered state
   ttib_regs_t s_d;  // next state

   // ---------------------------------------------------------------
   // address helper: truncate to 16 bits in compact mode
   // ---------------------------------------------------------------
   // a carry out of bit 15 is dropped in compact mode, as the word wraps
   function automatic logic [31:0] fit(input logic [31:0] a, input logic wide);
      fit = wide ? a : {16'h0000, a[15:0]};  // [RULE10]
   endfunction

   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      case (s_q.st)
         ttib_pkg::TTIB_ST_IDLE: begin
            // latch operands and issue the target read
            if (start_i) begin
               s_d.wide = (pointer_operand_mode_i != ttib_pkg::TTIB_MODE_COMPACT); // [RULE10]
               s_d.ptr  = fit(string_pointer_i, s_d.wide);
               s_d.base = fit(table_base_i, s_d.wide);
               s_d.cnt  = counter_i;
               s_d.addr = fit(string_pointer_i, s_d.wide); // [RULE1]
               s_d.req  = 1'b1;
               s_d.st   = ttib_pkg::TTIB_ST_TARGET;
            end
         end
         ttib_pkg::TTIB_ST_TARGET: begin
            if (mem_ack_i) begin
               // zero-extended index, at most 256 entries [RULE2] [RULE9]
               s_d.addr = fit(s_q.base + {24'h00_0000, mem_rdata_i}, s_q.wide);
               s_d.st   = ttib_pkg::TTIB_ST_XLATE;
            end
         end
         ttib_pkg::TTIB_ST_XLATE: begin
            // second answer: load result, step operands, retire
            if (mem_ack_i) begin
               s_d.res  = mem_rdata_i;                    // [RULE3]
               s_d.nul  = (mem_rdata_i == 8'h00);         // [RULE4]
               s_d.ptr  = fit(s_q.ptr + ttib_pkg::PTR_STEP, s_q.wide); // [RULE5]
               s_d.cnt  = s_q.cnt - ttib_pkg::CNT_STEP;   // [RULE6] [RULE12]
               s_d.exh  = (s_d.cnt == 16'h0000);          // [RULE6]
               s_d.req  = 1'b0;
               s_d.done = 1'b1;                           // [RULE11]
               s_d.st   = ttib_pkg::TTIB_ST_DONE;
            end
         end
         ttib_pkg::TTIB_ST_DONE: begin
            s_d.st = ttib_pkg::TTIB_ST_IDLE;  // no repeat [RULE11]
         end
         default: begin
            s_d.st  = ttib_pkg::TTIB_ST_IDLE;
            s_d.req = 1'b0;
         end
      endcase
      // busy follows the next state so busy_o is a plain flop
      s_d.busy = (s_d.st != ttib_pkg::TTIB_ST_IDLE);
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         // everything idle and zero while reset is low
         s_q <= '{st:   ttib_pkg::TTIB_ST_IDLE,
                  wide: 1'b0,
                  busy: 1'b0,
                  ptr:  ttib_pkg::ADDR_RST,
                  base: ttib_pkg::ADDR_RST,
                  cnt:  ttib_pkg::CNT_RST,
                  req:  1'b0,
                  addr: ttib_pkg::ADDR_RST,
                  done: 1'b0,
                  res:  ttib_pkg::BYTE_RST,
                  nul:  1'b0,
                  exh:  1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs straight from flops; table base has no output [RULE7]
   // ---------------------------------------------------------------
   assign mem_req_o          = s_q.req;
   assign mem_addr_o         = s_q.addr;
   assign busy_o             = s_q.busy;
   assign done_o             = s_q.done;
   assign result_byte_slot_o = s_q.res;
   assign string_pointer_o   = s_q.ptr;
   assign counter_o          = s_q.cnt;
   assign null_flag_o        = s_q.nul;
   assign exhausted_flag_o   = s_q.exh;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // all checks run on the rising edge and rest while reset is low

   // address path
   AST_TARGET_ADDR: assert property ( // [RULE1]
      (s_q.st == ttib_pkg::TTIB_ST_IDLE && start_i) |=>
         mem_req_o && mem_addr_o == fit($past(string_pointer_i),
            $past(pointer_operand_mode_i) != ttib_pkg::TTIB_MODE_COMPACT))
      else $error("target read not at string pointer");
   // a request and its address stay put until answered
   AST_REQ_HOLD: assert property ( // [RULE1]
      (mem_req_o && !mem_ack_i) |=> mem_req_o && $stable(mem_addr_o))
      else $error("request dropped before answer");
   // compact mode never shows a high word on the address or pointer
   AST_COMPACT_HI: assert property ( // [RULE10]
      (busy_o && !s_q.wide) |->
         mem_addr_o[31:16] == 16'h0000 && string_pointer_o[31:16] == 16'h0000)
      else $error("high word set in compact mode");
   AST_XLATE_ADDR: assert property ( // [RULE2]
      (s_q.st == ttib_pkg::TTIB_ST_TARGET && mem_ack_i) |=>
         mem_addr_o == fit(s_q.base + {24'h00_0000, $past(mem_rdata_i)}, s_q.wide))
      else $error("table address wrong");

   // result path
   AST_RESULT: assert property ( // [RULE3]
      (s_q.st == ttib_pkg::TTIB_ST_XLATE && mem_ack_i) |=>
         result_byte_slot_o == $past(mem_rdata_i) && done_o)
      else $error("result byte not loaded");
   AST_NULL: assert property ( // [RULE4]
      done_o |-> null_flag_o == (result_byte_slot_o == 8'h00))
      else $error("null flag mismatch");
   // result and flags move only on the retire cycle
   AST_FLAGS_HELD: assert property ( // [RULE4]
      !done_o |->
         $stable(result_byte_slot_o) && $stable(null_flag_o) && $stable(exhausted_flag_o))
      else $error("result or flags moved outside retire");
   AST_PTR_INC: assert property ( // [RULE5]
      (s_q.st == ttib_pkg::TTIB_ST_XLATE && mem_ack_i) |=>
         string_pointer_o == fit($past(s_q.ptr) + ttib_pkg::PTR_STEP, s_q.wide))
      else $error("pointer not incremented");
   AST_CNT_DEC: assert property ( // [RULE6]
      (s_q.st == ttib_pkg::TTIB_ST_XLATE && mem_ack_i) |=>
         counter_o == $past(s_q.cnt) - ttib_pkg::CNT_STEP &&
         exhausted_flag_o == (counter_o == 16'h0000))
      else $error("counter step wrong");

   // sequencing
   AST_BASE_KEPT: assert property ( // [RULE7]
      (s_q.st != ttib_pkg::TTIB_ST_IDLE) |=> $stable(s_q.base))
      else $error("table base changed");
   AST_ONE_SHOT: assert property ( // [RULE11]
      done_o |=> !busy_o && !mem_req_o ##1 !done_o)
      else $error("instruction repeated");
   // retire only straight after the answered table read
   AST_ORDER: assert property ( // [RULE11]
      done_o |-> $past(s_q.st) == ttib_pkg::TTIB_ST_XLATE && $past(mem_ack_i))
      else $error("retire out of order");
   // no request and no retire outside an instruction
   AST_IDLE_QUIET: assert property ( // [RULE11]
      !busy_o |-> !mem_req_o && !done_o)
      else $error("activity while idle");
   AST_WRAP: assert property ( // [RULE12]
      (done_o && $past(s_q.cnt) == 16'h0000) |-> counter_o == 16'hffff && !exhausted_flag_o)
      else $error("wrap sets exhausted");

   // ---------------------------------------------------------------
   // coverage of the main scenarios
   // ---------------------------------------------------------------
   COV_WAIT:  cover property (mem_req_o && !mem_ack_i ##1 mem_req_o && !mem_ack_i);
   COV_RUN:   cover property (start_i && !busy_o ##[2:20] done_o);
   COV_NULL:  cover property (done_o && null_flag_o);
   COV_EXH:   cover property (done_o && exhausted_flag_o);
   COV_WRAP:  cover property (done_o && counter_o == 16'hFFFF);
endmodule

// File: ttib_mem.sv
// memory read model that answers the unit's byte reads
`timescale 1ns/1ps
module ttib_mem (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // read port
   input  wire logic        mem_req_i,
   input  wire logic [31:0] mem_addr_i,
   input  wire logic [1:0]  dly_i,       // wait cycles before answering
   output logic             mem_ack_o,
   output logic [7:0]       mem_rdata_o
);
   logic [1:0] wait_q;                   // cycles waited so far
   // ---------------------------------------------------------------
   // answer: content is the xor of the four address bytes
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mem_ack_o   <= 1'b0;
         wait_q      <= 2'h0;
         mem_rdata_o <= 8'h00;
      end else if (mem_ack_o || !mem_req_i) begin
         // ack is a single pulse; stale data is inverted
         mem_ack_o   <= 1'b0;
         wait_q      <= 2'h0;
         mem_rdata_o <= ~mem_rdata_o;
      end else if (wait_q == dly_i) begin
         mem_ack_o   <= 1'b1;
         mem_rdata_o <= mem_addr_i[7:0] ^ mem_addr_i[15:8] ^ mem_addr_i[23:16] ^ mem_addr_i[31:24];
      end else begin
         // slow answer: data line keeps toggling meanwhile
         wait_q      <= wait_q + 2'h1;
         mem_rdata_o <= ~mem_rdata_o;
      end
   end
endmodule

// File: tb.sv
// testbench: random and corner-case runs of the translate-test-increment unit
`timescale 1ns/1ps
module tb;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic                 clk_i = 1'b0, rstn_i = 1'b0, start_i = 1'b0;
   ttib_pkg::ttib_mode_t mode  = ttib_pkg::TTIB_MODE_COMPACT;
   logic [31:0]          ptr = 32'h0000_0000, base = 32'h0000_0000, lfsr = 32'h0000_0001;
   logic [31:0]          addr, sp_o;
   logic [15:0]          cnt = 16'h0000, cnt_o;
   logic [7:0]           rdata, res;
   logic [1:0]           dly = 2'h0;
   logic                 req, ack, busy, done, nul, exh;
   int                   error_cnt = 0, samples_checked = 0, cyc = 0;
   ttib_unit u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i),
      .pointer_operand_mode_i(mode), .string_pointer_i(ptr), .table_base_i(base),
      .counter_i(cnt), .mem_req_o(req), .mem_addr_o(addr), .mem_ack_i(ack),
      .mem_rdata_i(rdata), .busy_o(busy), .done_o(done), .result_byte_slot_o(res),
      .string_pointer_o(sp_o), .counter_o(cnt_o), .null_flag_o(nul), .exhausted_flag_o(exh));
   ttib_mem u_mem (.clk_i(clk_i), .rstn_i(rstn_i), .mem_req_i(req), .mem_addr_i(addr),
      .dly_i(dly), .mem_ack_o(ack), .mem_rdata_o(rdata));
   // ---------------------------------------------------------------
   // clock and hang guard
   // ---------------------------------------------------------------
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc > 5000) begin
         error_cnt++;
         end_sim();
      end
   end
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] xb(input logic [31:0] a);
      return a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24];
   endfunction
   function automatic logic [31:0] nx(input logic [31:0] l);
      return {l[30:0], 1'b0} ^ (l[31] ? 32'h0400_0007 : 32'h0000_0000);
   endfunction
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         error_cnt++;
      end
   endtask
   task automatic end_sim();
      $display("checked %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // one instruction; operands are distinct ports, never overlapping
   task automatic run(input ttib_pkg::ttib_mode_t m, input logic [31:0] p, b,
                      input logic [15:0] c);
      logic [31:0] msk, ea;
      logic [7:0]  e;
      int          n;
      msk = (m == ttib_pkg::TTIB_MODE_COMPACT) ? 32'h0000_ffff : 32'hffff_ffff;
      ea  = (b + {24'h00_0000, xb(p & msk)}) & msk;
      e   = xb(ea);
      @(negedge clk_i);
      mode    = m;
      ptr     = p;
      base    = b;
      cnt     = c;
      dly     = lfsr[1:0];
      start_i = 1'b1;
      @(negedge clk_i);
      ptr = ~p;   // second start while busy must be ignored
      @(negedge clk_i);
      start_i = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 40) begin
         @(negedge clk_i);
         n++;
      end
      chk("done", 32'h0000_0001, {31'h0, done});
      chk("result", {24'h00_0000, e}, {24'h00_0000, res});
      chk("null", {31'h0, e == 8'h00}, {31'h0, nul});
      chk("pointer", (p + 32'h0000_0001) & msk, sp_o);
      chk("counter", {16'h0000, c - 16'h0001}, {16'h0000, cnt_o});
      chk("exhausted", {31'h0, c == 16'h0001}, {31'h0, exh});
      @(negedge clk_i);
      chk("retire", 32'h0000_0000, {30'h0, done, busy});
      $display("test end mode %0d pointer %h", m, p);
   endtask
   // ---------------------------------------------------------------
   // main sequence: reset, corners, random
   // ---------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk_i);
      @(negedge clk_i);
      rstn_i = 1'b1;
      run(ttib_pkg::TTIB_MODE_COMPACT, 32'h0001_ffff, 32'h0000_ff80, 16'h0000);
      run(ttib_pkg::TTIB_MODE_LINEAR, 32'h1234_5678, 32'h0000_1000, 16'h0001);
      run(ttib_pkg::TTIB_MODE_SEGMENTED, 32'h0000_0000, 32'h0101_0000, 16'h0002);
      run(ttib_pkg::TTIB_MODE_LINEAR, 32'h0000_00ff, 32'hffff_ff00, 16'hffff);
      for (int i = 0; i < 30; i++) begin
         lfsr = nx(lfsr);
         ptr  = lfsr;
         lfsr = nx(lfsr);
         run(ttib_pkg::ttib_mode_t'(2'(i % 3)), ptr, lfsr, lfsr[31:16]);
      end
      end_sim();
   end
endmodule
